// File: hdm_bus_cycle.sv
// hdm_bus_cycle.sv: one strobed read or write cycle on the internal data bus
`timescale 1ns/1ps
`default_nettype none
`include "hdm_cfg.svh"

module hdm_bus_cycle #(
    parameter int unsigned STROBE_CYC = `HDM_STROBE_CYC // must be 3 or more for the data sync
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire hdm_pkg::hdm_bus_s req_i,
    output logic busy_o,
    output logic done_o,
    output hdm_pkg::hdm_bus_s cur_o,
    output logic [`HDM_DATA_W-1:0] rdata_o,
    output logic [`HDM_ADDR_W-1:0] bus_addr_o,
    output logic [`HDM_DATA_W-1:0] bus_data_o,
    output logic bus_data_oe_n_o,
    input wire logic [`HDM_DATA_W-1:0] bus_data_i,
    output logic bus_wr_n_o,
    output logic bus_rd_n_o
);

    hdm_pkg::hdm_bus_st_e state; // sequencer state
    logic [`HDM_CNT_W-1:0] cnt; // strobe cycles left
    logic [`HDM_DATA_W-1:0] data_meta; // first sync stage
    logic [`HDM_DATA_W-1:0] data_sync; // second sync stage

    wire logic last = (state == hdm_pkg::BUS_STROBE) && (cnt == '0);

    assign busy_o = (state != hdm_pkg::BUS_IDLE);
    assign bus_addr_o = cur_o.addr;
    assign bus_data_o = cur_o.wdata;

    // bus data pins come from another device, two flops before use
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_meta <= 8'h00;
            data_sync <= 8'h00;
        end else begin
            data_meta <= bus_data_i;
            data_sync <= data_meta;
        end
    end

    // strobe sequencer: strobe rises with last, done pulses the same edge
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= hdm_pkg::BUS_IDLE;
            cnt <= '0;
            cur_o <= '0;
            rdata_o <= 8'h00;
            done_o <= 1'b0;
            bus_wr_n_o <= 1'b1;
            bus_rd_n_o <= 1'b1;
            bus_data_oe_n_o <= 1'b1;
        end else begin
            done_o <= 1'b0;
            case (state)
                hdm_pkg::BUS_IDLE: begin
                    if (start_i) begin
                        // latch request so the caller may change its fields
                        cur_o <= req_i;
                        cnt <= `HDM_CNT_W'(STROBE_CYC - 1);
                        state <= hdm_pkg::BUS_STROBE;
                        bus_wr_n_o <= ~req_i.we;
                        bus_rd_n_o <= req_i.we;
                        bus_data_oe_n_o <= ~req_i.we;
                    end
                end
                hdm_pkg::BUS_STROBE: begin
                    if (last) begin
                        // sample at the end of the enable pulse
                        rdata_o <= data_sync;
                        done_o <= 1'b1;
                        state <= hdm_pkg::BUS_IDLE;
                        bus_wr_n_o <= 1'b1;
                        bus_rd_n_o <= 1'b1;
                        bus_data_oe_n_o <= 1'b1;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: begin
                    state <= hdm_pkg::BUS_IDLE;
                end
            endcase
        end
    end

endmodule : hdm_bus_cycle
`default_nettype wire

// File: hdm_bus_model.sv
// hdm_bus_model.sv: behavioural latch on the internal bus pins
`timescale 1ns/1ps
`default_nettype none
module hdm_bus_model (
    input wire logic clk_i,
    input wire logic [7:0] data_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    output logic [7:0] data_o
);
    // stored byte, seeded so reads before any write are defined
    logic [7:0] mem = 8'h5a;
    // capture while the write strobe is low
    always_ff @(posedge clk_i) begin
        if (!wr_n_i) mem <= data_i;
    end
    // released bus shows the inverse, so a stale copy never passes
    assign data_o = rd_n_i ? ~mem : mem;
endmodule : hdm_bus_model
`default_nettype wire

// File: hdm_cfg.svh
// hdm_cfg.svh: constants of the hex debug monitor (key codes, addresses, timing)
`ifndef HDM_CFG_SVH
`define HDM_CFG_SVH

// key code width and codes delivered by the keypad scanner
`define HDM_KEY_W 5
`define HDM_KEY_HEX_LAST 5'h0f
`define HDM_KEY_SHIFT 5'h10
`define HDM_KEY_ADDR 5'h11
`define HDM_KEY_WRITE 5'h12
`define HDM_KEY_READ 5'h13
`define HDM_KEY_ROT 5'h14
`define HDM_KEY_FAST 5'h15
`define HDM_KEY_STEP 5'h16
`define HDM_KEY_PRESET 5'h17
`define HDM_KEY_START 5'h18

// bus map
`define HDM_ADDR_W 16
`define HDM_DATA_W 8
`define HDM_ADDR_STATUS 16'h1000
`define HDM_ADDR_DAC_HI 16'h3001
`define HDM_ADDR_DAC_LO 16'h3002
`define HDM_DAC_LO_W 4
`define HDM_STATUS_AIRFLOW_BIT 1

// display contents
`define HDM_ERR_NO_PLUGIN 8'h01
`define HDM_SWEEP_START_MHZ 16'h0000
`define HDM_SWEEP_STOP_MHZ 16'h2710

// timing, times in ns, counts in 100 MHz cycles
`define HDM_CLK_NS 10
`define HDM_STROBE_NS 40
`define HDM_STROBE_CYC ((`HDM_STROBE_NS + `HDM_CLK_NS - 1) / `HDM_CLK_NS)
`define HDM_RECYCLE_NS 30000
`define HDM_RECYCLE_CYC (`HDM_RECYCLE_NS / `HDM_CLK_NS)
`define HDM_LED_ON_NS 20000
`define HDM_LED_ON_CYC ((`HDM_LED_ON_NS + `HDM_CLK_NS - 1) / `HDM_CLK_NS)
`define HDM_READ_GAP_NS 10000
`define HDM_READ_GAP_CYC ((`HDM_READ_GAP_NS + `HDM_CLK_NS - 1) / `HDM_CLK_NS)
`define HDM_CNT_W 16

`endif

// File: hdm_key_decode.sv
// hdm_key_decode.sv: classifies a keypad code and yields its hex digit value
`timescale 1ns/1ps
`default_nettype none
`include "hdm_cfg.svh"

module hdm_key_decode (
    input wire logic [`HDM_KEY_W-1:0] code_i,
    output hdm_pkg::hdm_key_e key_o,
    output logic [3:0] nibble_o
);

    // codes 0..f: digits 0-9 then point, minus, GHz, MHz, dBm, backspace as a..f
    wire logic is_hex = (code_i <= `HDM_KEY_HEX_LAST);

    assign nibble_o = code_i[3:0];

    // command keys map one to one; anything unknown decodes as KEY_NONE
    assign key_o = is_hex ? hdm_pkg::KEY_HEX :
                   (code_i == `HDM_KEY_SHIFT) ? hdm_pkg::KEY_SHIFT :
                   (code_i == `HDM_KEY_ADDR) ? hdm_pkg::KEY_ADDR :
                   (code_i == `HDM_KEY_WRITE) ? hdm_pkg::KEY_WRITE :
                   (code_i == `HDM_KEY_READ) ? hdm_pkg::KEY_READ :
                   (code_i == `HDM_KEY_ROT) ? hdm_pkg::KEY_ROT :
                   (code_i == `HDM_KEY_FAST) ? hdm_pkg::KEY_FAST :
                   (code_i == `HDM_KEY_STEP) ? hdm_pkg::KEY_STEP :
                   (code_i == `HDM_KEY_PRESET) ? hdm_pkg::KEY_PRESET :
                   (code_i == `HDM_KEY_START) ? hdm_pkg::KEY_START :
                   hdm_pkg::KEY_NONE;

endmodule : hdm_key_decode
`default_nettype wire

// File: hdm_monitor.sv
// hdm_monitor.sv: front-panel hex debug monitor, key entry to bus operations
`timescale 1ns/1ps
`default_nettype none
`include "hdm_cfg.svh"

module hdm_monitor #(
    parameter int unsigned RECYCLE_CYC = `HDM_RECYCLE_CYC,
    parameter int unsigned LED_ON_CYC = `HDM_LED_ON_CYC,
    parameter int unsigned READ_GAP_CYC = `HDM_READ_GAP_CYC,
    parameter int unsigned STROBE_CYC = `HDM_STROBE_CYC,
    parameter int unsigned ROT_BITS = `HDM_DATA_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic key_valid_i,
    input wire logic [`HDM_KEY_W-1:0] key_code_i,
    input wire logic plugin_present_i,
    input wire logic airflow_fail_n_i,
    output logic [`HDM_ADDR_W-1:0] bus_addr_o,
    output logic [`HDM_DATA_W-1:0] bus_data_o,
    output logic bus_data_oe_n_o,
    input wire logic [`HDM_DATA_W-1:0] bus_data_i,
    output logic bus_wr_n_o,
    output logic bus_rd_n_o,
    output logic status_buffer_enable_n_o,
    output logic [`HDM_DATA_W-1:0] cw_dac_high_o,
    output logic [`HDM_DAC_LO_W-1:0] cw_dac_low_o,
    output logic [3:0] diag_led_o,
    output logic irq_service_en_o,
    output logic hex_mode_o,
    output hdm_pkg::hdm_disp_s disp_o
);

    // synchronised pin levels
    logic [1:0] pin_meta; // first stage, read only by pin_sync
    logic [1:0] pin_sync; // {plugin, airflow_n}
    wire logic plugin_ok = pin_sync[1];
    wire logic airflow_n = pin_sync[0];

    // key decode
    hdm_pkg::hdm_key_e key_cls; // class of the current key code
    logic [3:0] key_nib; // hex value of a digit key
    wire logic key_hex = key_valid_i && (key_cls == hdm_pkg::KEY_HEX);
    wire logic key_zero = key_hex && (key_nib == 4'h0);
    wire logic key_cmd = key_valid_i && (key_cls != hdm_pkg::KEY_HEX);

    // monitor state
    hdm_pkg::hdm_seq_e seq; // entry sequence tracker
    hdm_pkg::hdm_op_e op; // running operation
    logic [`HDM_ADDR_W-1:0] addr; // selected bus address
    logic addr_valid; // an address has been entered
    logic [3:0] hi_nib; // first write digit
    logic [`HDM_DATA_W-1:0] wbyte; // byte waiting to be written
    logic pend_wr; // single write waiting for the bus
    logic [$clog2(ROT_BITS)-1:0] rot_bit; // walking-one position
    logic [`HDM_CNT_W-1:0] gap; // wait before next loop cycle
    logic [`HDM_CNT_W-1:0] led_cnt; // self-test LED time left

    // bus sequencer links
    logic bus_busy; // cycle under way
    logic bus_done; // one-cycle end of cycle
    hdm_pkg::hdm_bus_s bus_cur; // request being run
    logic [`HDM_DATA_W-1:0] bus_rdata; // data sampled off the pins
    hdm_pkg::hdm_bus_s bus_req; // request offered now
    logic bus_start; // take bus_req now
    logic bus_rd_n_raw; // read enable from the sequencer

    // operation kinds that loop on the bus
    wire logic op_read = (op == hdm_pkg::OP_READ);
    wire logic op_rot = (op == hdm_pkg::OP_ROT);
    wire logic op_fast = (op == hdm_pkg::OP_FAST);
    // write and loop commands need an address first
    wire logic cmd_ok = hex_mode_o && addr_valid;

    // walking-one pattern for the current position
    wire logic [`HDM_DATA_W-1:0] rot_pat = `HDM_DATA_W'(1) << rot_bit;
    wire logic rot_last = (32'(rot_bit) == ROT_BITS - 1);

    // local decode of the documented registers
    wire logic hit_status = (bus_cur.addr == `HDM_ADDR_STATUS);
    wire logic hit_dac_hi = (bus_cur.addr == `HDM_ADDR_DAC_HI);
    wire logic hit_dac_lo = (bus_cur.addr == `HDM_ADDR_DAC_LO);
    // airflow fail pin is active low, reads as a one on D1
    wire logic [`HDM_DATA_W-1:0] status_byte = `HDM_DATA_W'(!airflow_n) << `HDM_STATUS_AIRFLOW_BIT;
    wire logic [`HDM_DATA_W-1:0] rd_byte = hit_status ? status_byte : bus_rdata;

    // bus issue: a single write first, then whichever loop is running
    assign bus_start = !bus_busy && (pend_wr || ((op_read || op_rot) && gap == '0) || op_fast);
    assign bus_req.addr = addr;
    assign bus_req.wdata = pend_wr ? wbyte : rot_pat;
    assign bus_req.we = pend_wr || op_rot;

    // the status buffer sits on the bus only through its own enable
    assign status_buffer_enable_n_o = bus_rd_n_raw || !hit_status;
    assign bus_rd_n_o = bus_rd_n_raw || hit_status;

    // interrupts are held off while rotation write owns the bus
    assign irq_service_en_o = !op_rot;

    assign diag_led_o = (led_cnt != '0) ? 4'hf : 4'h0;

    hdm_key_decode u_key (
        .code_i(key_code_i),
        .key_o(key_cls),
        .nibble_o(key_nib)
    );

    hdm_bus_cycle #(
        .STROBE_CYC(STROBE_CYC)
    ) u_bus (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .start_i(bus_start),
        .req_i(bus_req),
        .busy_o(bus_busy),
        .done_o(bus_done),
        .cur_o(bus_cur),
        .rdata_o(bus_rdata),
        .bus_addr_o(bus_addr_o),
        .bus_data_o(bus_data_o),
        .bus_data_oe_n_o(bus_data_oe_n_o),
        .bus_data_i(bus_data_i),
        .bus_wr_n_o(bus_wr_n_o),
        .bus_rd_n_o(bus_rd_n_raw)
    );

    // plug-in sense and airflow pins, two flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_meta <= 2'h1;
            pin_sync <= 2'h1;
        end else begin
            pin_meta <= {plugin_present_i, airflow_fail_n_i};
            pin_sync <= pin_meta;
        end
    end

    // shift 0 0 opens hex mode; preset closes it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq <= hdm_pkg::SEQ_IDLE;
            hex_mode_o <= 1'b0;
        end else if (key_valid_i) begin
            // any key that breaks the sequence starts it over
            seq <= hdm_pkg::SEQ_IDLE;
            case (seq)
                hdm_pkg::SEQ_IDLE: begin
                    if (key_cls == hdm_pkg::KEY_SHIFT) begin
                        seq <= hdm_pkg::SEQ_SHIFT;
                    end
                end
                hdm_pkg::SEQ_SHIFT: begin
                    if (key_zero) begin
                        seq <= hdm_pkg::SEQ_SHIFT0;
                    end
                end
                hdm_pkg::SEQ_SHIFT0: begin
                    if (key_zero) begin
                        hex_mode_o <= 1'b1;
                    end
                end
                default: begin
                    seq <= hdm_pkg::SEQ_IDLE;
                end
            endcase
            if (key_cls == hdm_pkg::KEY_PRESET) begin
                hex_mode_o <= 1'b0;
            end
        end
    end

    // key-driven operation state; any new command except step ends a running loop
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op <= hdm_pkg::OP_IDLE;
            addr <= 16'h0000;
            addr_valid <= 1'b0;
            hi_nib <= 4'h0;
            wbyte <= 8'h00;
            pend_wr <= 1'b0;
        end else begin
            // the bus takes a single write before any loop cycle
            if (bus_start && pend_wr) begin
                pend_wr <= 1'b0;
            end
            if (key_valid_i && key_cls == hdm_pkg::KEY_PRESET) begin
                op <= hdm_pkg::OP_IDLE;
                addr_valid <= 1'b0;
            end else if (key_hex && hex_mode_o) begin
                case (op)
                    hdm_pkg::OP_ADDR: begin
                        addr <= {addr[`HDM_ADDR_W-5:0], key_nib};
                        addr_valid <= 1'b1;
                    end
                    hdm_pkg::OP_WDIG1: begin
                        hi_nib <= key_nib;
                        op <= hdm_pkg::OP_WDIG2;
                    end
                    hdm_pkg::OP_WDIG2: begin
                        wbyte <= {hi_nib, key_nib};
                        pend_wr <= 1'b1;
                        op <= hdm_pkg::OP_IDLE;
                    end
                    default: begin
                        op <= op; // digits outside entry are ignored
                    end
                endcase
            end else if (key_cmd && hex_mode_o) begin
                case (key_cls)
                    hdm_pkg::KEY_ADDR: begin
                        op <= hdm_pkg::OP_ADDR;
                        addr <= 16'h0000;
                        addr_valid <= 1'b0;
                    end
                    hdm_pkg::KEY_STEP: begin
                        addr <= addr + 1'b1;
                    end
                    hdm_pkg::KEY_WRITE: begin
                        op <= cmd_ok ? hdm_pkg::OP_WDIG1 : hdm_pkg::OP_IDLE;
                    end
                    hdm_pkg::KEY_READ: begin
                        op <= cmd_ok ? hdm_pkg::OP_READ : hdm_pkg::OP_IDLE;
                    end
                    hdm_pkg::KEY_ROT: begin
                        op <= cmd_ok ? hdm_pkg::OP_ROT : hdm_pkg::OP_IDLE;
                    end
                    hdm_pkg::KEY_FAST: begin
                        op <= cmd_ok ? hdm_pkg::OP_FAST : hdm_pkg::OP_IDLE;
                    end
                    default: begin
                        op <= hdm_pkg::OP_IDLE; // other command stops the loop
                    end
                endcase
            end
        end
    end

    // loop pacing: read refresh gap, walking-one position and recycle hold
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rot_bit <= '0;
            gap <= '0;
        end else if (!(op_read || op_rot)) begin
            // fresh start for the next loop
            rot_bit <= '0;
            gap <= '0;
        end else if (bus_start && !pend_wr && op_rot) begin
            // advance as each write is issued, since the next start may fall in the done cycle
            if (rot_last) begin
                rot_bit <= '0;
                gap <= `HDM_CNT_W'(STROBE_CYC + RECYCLE_CYC - 1);
            end else begin
                rot_bit <= rot_bit + 1'b1;
            end
        end else if (bus_start && !pend_wr && op_read) begin
            // gap runs from the start, so the idle time after done is the refresh gap plus one
            gap <= `HDM_CNT_W'(STROBE_CYC + READ_GAP_CYC);
        end else if (gap != '0) begin
            gap <= gap - 1'b1;
        end
    end

    // on-chip latches catch writes to their addresses
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cw_dac_high_o <= 8'h00;
            cw_dac_low_o <= 4'h0;
        end else if (bus_done && bus_cur.we) begin
            if (hit_dac_hi) begin
                cw_dac_high_o <= bus_cur.wdata;
            end
            if (hit_dac_lo) begin
                // only d0..d3 are wired, first digit is don't care
                cw_dac_low_o <= bus_cur.wdata[`HDM_DAC_LO_W-1:0];
            end
        end
    end

    // self-test LEDs: lit at power on and on preset, cleared when done
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            led_cnt <= `HDM_CNT_W'(LED_ON_CYC);
        end else if (key_valid_i && key_cls == hdm_pkg::KEY_PRESET) begin
            led_cnt <= `HDM_CNT_W'(LED_ON_CYC);
        end else if (led_cnt != '0) begin
            led_cnt <= led_cnt - 1'b1;
        end
    end

    // front display contents
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            disp_o <= '0;
        end else if (key_valid_i && key_cls == hdm_pkg::KEY_PRESET) begin
            // preset with an empty plug-in bay reports error 001
            disp_o.kind <= plugin_ok ? hdm_pkg::DISP_BLANK : hdm_pkg::DISP_ERROR;
            disp_o.err_code <= `HDM_ERR_NO_PLUGIN;
        end else if (key_valid_i && key_cls == hdm_pkg::KEY_START && !plugin_ok) begin
            disp_o.kind <= hdm_pkg::DISP_SWEEP;
            disp_o.start_mhz <= `HDM_SWEEP_START_MHZ;
            disp_o.stop_mhz <= `HDM_SWEEP_STOP_MHZ;
        end else if (bus_done && op_read && !bus_cur.we) begin
            // fast read leaves the display alone, it would only flicker
            disp_o.kind <= hdm_pkg::DISP_HEX;
            disp_o.hex_byte <= rd_byte;
        end
    end

endmodule : hdm_monitor
`default_nettype wire

// File: hdm_monitor_checker.sv
// hdm_monitor_checker.sv: port assertions for the hex debug monitor
`timescale 1ns/1ps
`default_nettype none
`include "hdm_cfg.svh"
module hdm_monitor_checker (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic key_valid_i,
    input wire logic [`HDM_KEY_W-1:0] key_code_i,
    input wire logic [`HDM_ADDR_W-1:0] bus_addr_o,
    input wire logic [`HDM_DATA_W-1:0] bus_data_o,
    input wire logic bus_data_oe_n_o,
    input wire logic bus_wr_n_o,
    input wire logic bus_rd_n_o,
    input wire logic status_buffer_enable_n_o,
    input wire logic [`HDM_DATA_W-1:0] cw_dac_high_o,
    input wire logic [`HDM_DAC_LO_W-1:0] cw_dac_low_o,
    input wire logic irq_service_en_o,
    input wire logic hex_mode_o,
    input wire hdm_pkg::hdm_disp_s disp_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // preset key taken this cycle
    wire pk = key_valid_i && key_code_i == `HDM_KEY_PRESET;
    // strobe width fixed at four cycles in this bench
    property p_wr_width; $fell(bus_wr_n_o) |-> (!bus_wr_n_o)[*4] ##1 bus_wr_n_o; endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");
    property p_wr_oe; !bus_wr_n_o |-> !bus_data_oe_n_o; endproperty
    a_wr_oe: assert property (p_wr_oe) else $error("data driver off during write");
    property p_dac_hi; $rose(bus_wr_n_o) && bus_addr_o == `HDM_ADDR_DAC_HI |-> ##[0:1] cw_dac_high_o == bus_data_o;
    endproperty
    a_dac_hi: assert property (p_dac_hi) else $error("high latch missed write");
    property p_dac_lo;
        $rose(bus_wr_n_o) && bus_addr_o == `HDM_ADDR_DAC_LO |-> ##[0:1] cw_dac_low_o == bus_data_o[3:0];
    endproperty
    a_dac_lo: assert property (p_dac_lo) else $error("low latch missed write");
    property p_sbe; !status_buffer_enable_n_o |-> bus_rd_n_o && bus_addr_o == `HDM_ADDR_STATUS; endproperty
    a_sbe: assert property (p_sbe) else $error("status enable at wrong address");
    property p_rot_hot; !bus_wr_n_o && !irq_service_en_o |-> $onehot(bus_data_o); endproperty
    a_rot_hot: assert property (p_rot_hot) else $error("rotation data not one-hot");
    // no write for eight cycles after the last bit, the start of the recycle delay
    property p_rot_gap; $rose(bus_wr_n_o) && !irq_service_en_o && bus_data_o == 8'h80 |-> bus_wr_n_o[*8]; endproperty
    a_rot_gap: assert property (p_rot_gap) else $error("no recycle delay after last bit");
    property p_hex_exit; $fell(hex_mode_o) |-> $past(pk); endproperty
    a_hex_exit: assert property (p_hex_exit) else $error("hex mode left without preset");
    property p_sweep;
        disp_o.kind == hdm_pkg::DISP_SWEEP |-> disp_o.start_mhz == 16'h0000 && disp_o.stop_mhz == 16'h2710;
    endproperty
    a_sweep: assert property (p_sweep) else $error("sweep limits wrong");
    c_rot: cover property ($fell(bus_wr_n_o) && !irq_service_en_o);
    c_sbe: cover property ($fell(status_buffer_enable_n_o));
    c_sweep: cover property (disp_o.kind == hdm_pkg::DISP_SWEEP);
endmodule : hdm_monitor_checker
bind hdm_monitor hdm_monitor_checker i_hdm_monitor_checker (.clk_i(clk_i), .rstn_i(rstn_i),
    .key_valid_i(key_valid_i), .key_code_i(key_code_i), .bus_addr_o(bus_addr_o), .bus_data_o(bus_data_o),
    .bus_data_oe_n_o(bus_data_oe_n_o), .bus_wr_n_o(bus_wr_n_o), .bus_rd_n_o(bus_rd_n_o),
    .status_buffer_enable_n_o(status_buffer_enable_n_o), .cw_dac_high_o(cw_dac_high_o),
    .cw_dac_low_o(cw_dac_low_o), .irq_service_en_o(irq_service_en_o), .hex_mode_o(hex_mode_o), .disp_o(disp_o));
`default_nettype wire

// File: hdm_monitor_tb_top.sv
// hdm_monitor_tb_top.sv: self-checking bench of the hex debug monitor
`timescale 1ns/1ps
`default_nettype none
`include "hdm_cfg.svh"
module hdm_monitor_tb_top;
    logic clk = 0, rst_n = 0, kv = 0, plug = 0, air_n = 1, oe_n, wr_n, rd_n, sbe_n, irq, hexm;
    logic [4:0] kc = 5'h00;
    logic [15:0] addr;
    logic [7:0] dout, din, dhi;
    logic [3:0] dlo, led;
    hdm_pkg::hdm_disp_s disp;
    int errors = 0, checked = 0, nw = 0, nr = 0, ns = 0, n0;
    logic [7:0] wlog [$];
    realtime tq [$];
    logic [7:0] pat [5] = '{8'h55, 8'haa, 8'hab, 8'hcd, 8'hef};
    initial forever #5 clk = ~clk;
    // strobe counters and rotation log
    always @(negedge wr_n) nw++;
    always @(negedge rd_n) nr++;
    always @(negedge sbe_n) ns++;
    always @(posedge wr_n) if (rst_n) begin
        wlog.push_back(dout);
        tq.push_back($realtime);
    end
    hdm_monitor #(.RECYCLE_CYC(20), .LED_ON_CYC(10), .READ_GAP_CYC(5), .STROBE_CYC(4)) i_hdm_monitor (
        .clk_i(clk), .rstn_i(rst_n), .key_valid_i(kv), .key_code_i(kc), .plugin_present_i(plug),
        .airflow_fail_n_i(air_n), .bus_addr_o(addr), .bus_data_o(dout), .bus_data_oe_n_o(oe_n),
        .bus_data_i(din), .bus_wr_n_o(wr_n), .bus_rd_n_o(rd_n), .status_buffer_enable_n_o(sbe_n),
        .cw_dac_high_o(dhi), .cw_dac_low_o(dlo), .diag_led_o(led), .irq_service_en_o(irq),
        .hex_mode_o(hexm), .disp_o(disp));
    hdm_bus_model i_hdm_bus_model (.clk_i(clk), .data_i(dout), .wr_n_i(wr_n), .rd_n_i(rd_n), .data_o(din));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one-cycle key strobe, driven at the falling edge
    task automatic key(input logic [4:0] c);
        @(negedge clk);
        kv = 1;
        kc = c;
        @(negedge clk);
        kv = 0;
    endtask : key
    task automatic keys(input logic [4:0] s [$]);
        foreach (s[i]) key(s[i]);
    endtask : keys
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    task automatic end_sim;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // watchdog well past the expected run of about five hundred cycles
    initial begin
        #200us;
        errors++;
        end_sim();
    end
    initial begin
        wt(16);
        rst_n = 1;
        wt(1);
        chk(led, 4'hf);
        wt(12);
        chk(led, 4'h0);
        keys('{`HDM_KEY_ADDR, 5'h03, 5'h00, 5'h00, 5'h01, `HDM_KEY_WRITE, 5'h05, 5'h05});
        wt(12);
        chk(nw, 0);
        key(`HDM_KEY_PRESET);
        wt(2);
        chk(disp.kind, hdm_pkg::DISP_ERROR);
        chk(disp.err_code, 8'h01);
        key(`HDM_KEY_START);
        wt(2);
        chk(disp.kind, hdm_pkg::DISP_SWEEP);
        chk(disp.stop_mhz, 16'h2710);
        keys('{`HDM_KEY_SHIFT, 5'h00, 5'h00});
        wt(2);
        chk(hexm, 1'b1);
        keys('{`HDM_KEY_WRITE, 5'h05, 5'h05});
        wt(12);
        chk(nw, 0);
        keys('{`HDM_KEY_ADDR, 5'h03, 5'h00, 5'h00, 5'h01});
        foreach (pat[i]) begin
            keys('{`HDM_KEY_WRITE, {1'b0, pat[i][7:4]}, {1'b0, pat[i][3:0]}});
            wt(12);
            chk(dhi, pat[i]);
        end
        keys('{`HDM_KEY_STEP, `HDM_KEY_WRITE, 5'h00, 5'h07});
        wt(12);
        chk(dlo, 4'h7);
        chk(dhi, 8'hef);
        keys('{`HDM_KEY_ADDR, 5'h02, 5'h00, 5'h00, 5'h00, `HDM_KEY_WRITE, 5'h03, 5'h0c, `HDM_KEY_READ});
        wt(20);
        chk(disp.hex_byte, 8'h3c);
        keys('{`HDM_KEY_ADDR, 5'h01, 5'h00, 5'h00, 5'h00});
        air_n = 0;
        n0 = nr;
        key(`HDM_KEY_READ);
        wt(20);
        chk(disp.hex_byte, 8'h02);
        chk(disp.kind, hdm_pkg::DISP_HEX);
        n0 = ns;
        air_n = 1;
        wt(30);
        chk(ns > n0 + 1, 1'b1);
        chk(disp.hex_byte, 8'h00);
        keys('{`HDM_KEY_ADDR, 5'h02, 5'h00, 5'h00, 5'h00});
        wlog.delete();
        tq.delete();
        key(`HDM_KEY_ROT);
        wt(8);
        chk(irq, 1'b0);
        wt(80);
        for (int i = 0; i < 9; i++) chk(wlog[i], 8'h01 << (i % 8));
        chk(tq[8] - tq[7] >= 240.0, 1'b1);
        key(`HDM_KEY_FAST);
        wt(12);
        chk(irq, 1'b1);
        n0 = nr;
        wt(50);
        chk(nr - n0 >= 8, 1'b1);
        key(`HDM_KEY_PRESET);
        wt(2);
        chk(hexm, 1'b0);
        chk(led, 4'hf);
        end_sim();
    end
endmodule : hdm_monitor_tb_top
`default_nettype wire

// File: hdm_pkg.sv
// hdm_pkg.sv: types shared by the hex debug monitor modules
`default_nettype none
`include "hdm_cfg.svh"

package hdm_pkg;

    // decoded key classes
    typedef enum logic [3:0] {
        KEY_NONE, KEY_HEX, KEY_SHIFT, KEY_ADDR, KEY_WRITE, KEY_READ,
        KEY_ROT, KEY_FAST, KEY_STEP, KEY_PRESET, KEY_START
    } hdm_key_e;

    // monitor operation state
    typedef enum logic [2:0] {
        OP_IDLE, OP_ADDR, OP_WDIG1, OP_WDIG2, OP_READ, OP_ROT, OP_FAST
    } hdm_op_e;

    // hex-mode entry sequence
    typedef enum logic [1:0] {
        SEQ_IDLE, SEQ_SHIFT, SEQ_SHIFT0
    } hdm_seq_e;

    // bus cycle sequencer state
    typedef enum logic [0:0] {
        BUS_IDLE, BUS_STROBE
    } hdm_bus_st_e;

    // what the front display shows
    typedef enum logic [1:0] {
        DISP_BLANK, DISP_HEX, DISP_ERROR, DISP_SWEEP
    } hdm_disp_e;

    // one bus request
    typedef struct packed {
        logic [`HDM_ADDR_W-1:0] addr;
        logic [`HDM_DATA_W-1:0] wdata;
        logic we;
    } hdm_bus_s;

    // display contents
    typedef struct packed {
        hdm_disp_e kind;
        logic [`HDM_DATA_W-1:0] hex_byte;
        logic [7:0] err_code;
        logic [15:0] start_mhz;
        logic [15:0] stop_mhz;
    } hdm_disp_s;

endpackage : hdm_pkg
`default_nettype wire
